// ==== design/acc_ctrl_defs.vh ====
// Constants for the accessory detect and switch control block
`ifndef ACC_CTRL_DEFS_VH
`define ACC_CTRL_DEFS_VH
`define CLK_MHZ 50
`define OVP_TRIP_NS 1000
`define OVP_TRIP_CYC ((`OVP_TRIP_NS * `CLK_MHZ) / 1000)
`define RECOV_US 10
`define RECOV_CYC (`RECOV_US * `CLK_MHZ)
`define SWRST_MS 30
`define SWRST_CYC (`SWRST_MS * 1000 * `CLK_MHZ)
`define AV_HOLD_US 100
`define AV_HOLD_CYC (`AV_HOLD_US * `CLK_MHZ)
`define ADC_W 5
`define SW_W 8
`define ADC_OTG 5'h00
`define ADC_T1_CHG 5'h17
`define ADC_T2_CHG 5'h1b
`define ADC_AV 5'h1a
`define ADC_UART 5'h16
`define ADC_NONE 5'h1f
`define SW_OPEN 8'h00
`define SW_USB 8'h01
`define SW_UART 8'h02
`define SW_AUDIO 8'h04
`define SW_VIDEO 8'h08
`define SW_VBUS 8'h10
`endif

// ==== design/accessory_detect_switch_ctrl.v ====
// Accessory detection, switch steering, OVP flags and soft reset control
`timescale 1ns/1ps
`include "acc_ctrl_defs.vh"
module accessory_detect_switch_ctrl #(
    parameter SWRST_CYC = `SWRST_CYC,
    parameter RECOV_CYC = `RECOV_CYC,
    parameter AV_HOLD_CYC = `AV_HOLD_CYC
) (
    // Clock and power-on reset
    input wire i_sys_clk,
    input wire i_srst,
    // Comparators and ADC
    input wire i_vbus_high,
    input wire i_id_below_ref,
    input wire i_ov_weak,
    input wire i_ov_strong,
    input wire i_below_hys,
    input wire i_above_uvlo,
    input wire i_sync_pulse,
    input wire [`ADC_W-1:0] i_adc_code,
    input wire i_adc_done,
    output wire o_adc_start,
    output wire o_imp_measure,
    // Host control
    input wire i_manual_mode,
    input wire [`SW_W-1:0] i_manual_sw,
    input wire i_int_read,
    input wire i_int_mask,
    input wire i_scl_low,
    input wire i_sda_low,
    // Status and drive
    output reg [`ADC_W-1:0] o_acc_type_ff,
    output reg o_attached_ff,
    output reg [`SW_W-1:0] o_switch_ff,
    output wire o_vbus_switch_on,
    output reg o_overvoltage_flag_ff,
    output reg o_overvoltage_cleared_flag_ff,
    output reg o_attach_flag_ff,
    output reg o_detach_flag_ff,
    output reg o_interrupt_out_n_ff,
    output wire o_standby
);
    localparam ST_STANDBY = 4'b0001;
    localparam ST_MEASURE = 4'b0010;
    localparam ST_ATTACHED = 4'b0100;
    localparam ST_AV_HOLD = 4'b1000;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [31:0] swrst_cnt_ff;
    reg [31:0] av_cnt_ff;
    reg soft_rst_ff;
    reg int_hold_ff;
    wire ov_tripped;
    wire ov_trip;
    wire ov_clear;
    wire rst = i_srst | soft_rst_ff;

    function is_charger;
        input [`ADC_W-1:0] code;
        begin
            is_charger = (code == `ADC_T1_CHG) || (code == `ADC_T2_CHG);
        end
    endfunction

    // Automatic routing table; charger-only paths leave data switches open
    function [`SW_W-1:0] auto_route;
        input [`ADC_W-1:0] code;
        input vbus;
        begin
            case (code)
                `ADC_OTG: auto_route = `SW_USB;
                `ADC_UART: auto_route = `SW_UART;
                `ADC_AV: auto_route = `SW_VIDEO | `SW_AUDIO;
                `ADC_NONE: auto_route = vbus ? `SW_USB : `SW_OPEN;
                default: auto_route = is_charger(code) ? `SW_OPEN : `SW_AUDIO;
            endcase
        end
    endfunction

    ovp_integrator #(
        .TRIP_CYC(`OVP_TRIP_CYC),
        .RECOV_CYC(RECOV_CYC),
        .W(16)
    ) u_ovp (
        .i_sys_clk(i_sys_clk),
        .i_srst(rst),
        .i_ov_weak(i_ov_weak),
        .i_ov_strong(i_ov_strong),
        .i_above_uvlo(i_above_uvlo),
        .i_below_hys(i_below_hys),
        .o_tripped(ov_tripped),
        .o_trip_pulse_ff(ov_trip),
        .o_clear_pulse_ff(ov_clear)
    );

    assign o_vbus_switch_on = ~ov_tripped;
    assign o_standby = state_ff == ST_STANDBY;
    assign o_adc_start = state_ff == ST_MEASURE;
    // Impedance path used only with supply present and no charger seen yet
    assign o_imp_measure = (state_ff == ST_MEASURE) && i_vbus_high;

    wire insert = i_vbus_high | i_id_below_ref;
    wire gone = ~i_vbus_high & ~i_id_below_ref;

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STANDBY:
                if (insert)
                    nxt_state = ST_MEASURE;
            ST_MEASURE:
                if (gone)
                    nxt_state = ST_STANDBY;
                else if (i_adc_done)
                    nxt_state = ST_ATTACHED;
            ST_ATTACHED:
                if (gone)
                    nxt_state = (o_acc_type_ff == `ADC_AV) ? ST_AV_HOLD : ST_STANDBY;
                else if (i_adc_done && !i_vbus_high)
                    nxt_state = ST_ATTACHED;
            ST_AV_HOLD:
                if (insert)
                    nxt_state = ST_ATTACHED;
                else if (av_cnt_ff >= AV_HOLD_CYC - 1)
                    nxt_state = ST_STANDBY;
            default:
                nxt_state = ST_STANDBY;
        endcase
    end

    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            swrst_cnt_ff <= 32'h0000_0000;
            soft_rst_ff <= 1'b0;
        end
        else if (i_scl_low && i_sda_low)
        begin
            if (swrst_cnt_ff >= SWRST_CYC - 1)
                soft_rst_ff <= 1'b1;
            else
                swrst_cnt_ff <= swrst_cnt_ff + 32'h0000_0001;
        end
        else
        begin
            swrst_cnt_ff <= 32'h0000_0000;
            soft_rst_ff <= 1'b0;
        end
    end

    always @(posedge i_sys_clk)
    begin
        if (i_srst)
            int_hold_ff <= 1'b0;
        else if (soft_rst_ff)
            int_hold_ff <= 1'b1;
        else if (!i_int_mask)
            int_hold_ff <= 1'b0;
    end

    always @(posedge i_sys_clk)
    begin
        if (rst)
        begin
            state_ff <= ST_STANDBY;
            o_acc_type_ff <= `ADC_NONE;
            o_attached_ff <= 1'b0;
            o_switch_ff <= `SW_OPEN;
            av_cnt_ff <= 32'h0000_0000;
            o_overvoltage_flag_ff <= 1'b0;
            o_overvoltage_cleared_flag_ff <= 1'b0;
            o_attach_flag_ff <= 1'b0;
            o_detach_flag_ff <= 1'b0;
            o_interrupt_out_n_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            if (i_adc_done && (state_ff == ST_MEASURE || state_ff == ST_ATTACHED))
                o_acc_type_ff <= i_adc_code;
            else if (nxt_state == ST_STANDBY)
                o_acc_type_ff <= `ADC_NONE;
            o_attached_ff <= (nxt_state == ST_ATTACHED) || (nxt_state == ST_AV_HOLD);
            // Sync pulses on the video load restart the hold window
            if (state_ff != ST_AV_HOLD || i_sync_pulse)
                av_cnt_ff <= 32'h0000_0000;
            else
                av_cnt_ff <= av_cnt_ff + 32'h0000_0001;
            if (i_manual_mode)
                o_switch_ff <= i_manual_sw;
            else
                o_switch_ff <= auto_route(o_acc_type_ff, i_vbus_high);
            // Set wins over a read-clear in the same cycle
            o_overvoltage_flag_ff <= ov_trip | (o_overvoltage_flag_ff & ~i_int_read);
            o_overvoltage_cleared_flag_ff <= ov_clear
                | (o_overvoltage_cleared_flag_ff & ~i_int_read);
            o_attach_flag_ff <= (state_ff == ST_MEASURE && nxt_state == ST_ATTACHED)
                | (o_attach_flag_ff & ~i_int_read);
            o_detach_flag_ff <= (state_ff != ST_STANDBY && nxt_state == ST_STANDBY)
                | (o_detach_flag_ff & ~i_int_read);
            o_interrupt_out_n_ff <= ~(int_hold_ff | (!i_int_mask &
                (o_overvoltage_flag_ff | o_overvoltage_cleared_flag_ff
                | o_attach_flag_ff | o_detach_flag_ff) & ~i_int_read));
        end
    end
endmodule // accessory_detect_switch_ctrl

// ==== design/ovp_integrator.v ====
// Overvoltage glitch integrator and recovery deglitch timer
`timescale 1ns/1ps
`include "acc_ctrl_defs.vh"
module ovp_integrator #(
    parameter TRIP_CYC = `OVP_TRIP_CYC,
    parameter RECOV_CYC = `RECOV_CYC,
    parameter W = 16
) (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_srst,
    // Comparator inputs
    input wire i_ov_weak,
    input wire i_ov_strong,
    input wire i_above_uvlo,
    input wire i_below_hys,
    // Status
    output wire o_tripped,
    output reg o_trip_pulse_ff,
    output reg o_clear_pulse_ff
);
    reg [W-1:0] integ_ff;
    reg [W-1:0] recov_ff;
    reg tripped_ff;
    wire [W-1:0] trip_lim = TRIP_CYC[W-1:0];
    // Strong excursions charge twice as fast, so they trip in half the time
    wire [W-1:0] step = i_ov_strong ? 16'h0002 : 16'h0001;
    wire trip_now = (integ_ff + step >= trip_lim) && (i_ov_weak || i_ov_strong);
    assign o_tripped = tripped_ff;
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            integ_ff <= 16'h0000;
            recov_ff <= 16'h0000;
            tripped_ff <= 1'b0;
            o_trip_pulse_ff <= 1'b0;
            o_clear_pulse_ff <= 1'b0;
        end
        else
        begin
            o_trip_pulse_ff <= 1'b0;
            o_clear_pulse_ff <= 1'b0;
            if (!tripped_ff)
            begin
                if (trip_now)
                begin
                    tripped_ff <= 1'b1;
                    o_trip_pulse_ff <= 1'b1;
                    integ_ff <= 16'h0000;
                end
                else if (i_ov_weak || i_ov_strong)
                    integ_ff <= integ_ff + step;
                else if (integ_ff != 16'h0000)
                    integ_ff <= integ_ff - 16'h0001;
                recov_ff <= 16'h0000;
            end
            else if (i_below_hys && i_above_uvlo)
            begin
                if (recov_ff >= RECOV_CYC[W-1:0] - 16'h0001)
                begin
                    tripped_ff <= 1'b0;
                    o_clear_pulse_ff <= 1'b1;
                    recov_ff <= 16'h0000;
                end
                else
                    recov_ff <= recov_ff + 16'h0001;
            end
            else
                recov_ff <= 16'h0000;
        end
    end
endmodule // ovp_integrator

// ==== sim/acc_adc_model.sv ====
// Behavioural ID-line ADC that answers each conversion request
`timescale 1ns/1ps
`include "acc_ctrl_defs.vh"
module acc_adc_model (
    // Clock
    input wire i_sys_clk,
    // Request and result
    input wire i_start,
    input wire [3:0] i_lat,
    input wire [`ADC_W-1:0] i_code,
    output reg o_done,
    output reg [`ADC_W-1:0] o_code
);
    reg [3:0] cnt_ff = 4'h0;
    initial o_done = 1'b0;
    initial o_code = 5'h00;
    always @(posedge i_sys_clk)
    begin
        o_done <= 1'b0;
        // Stale code keeps changing so it never passes for a result
        o_code <= ~o_code;
        cnt_ff <= i_start ? cnt_ff + 4'h1 : 4'h0;
        if (i_start && cnt_ff == i_lat)
        begin
            o_done <= 1'b1;
            o_code <= i_code;
            cnt_ff <= 4'h0;
        end
    end
endmodule // acc_adc_model

// ==== sim/accessory_detect_switch_ctrl_monitor.sv ====
// Concurrent checks on the accessory control block ports
`timescale 1ns/1ps
`include "acc_ctrl_defs.vh"
module accessory_detect_switch_ctrl_monitor (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_srst,
    // Inputs watched
    input wire i_vbus_high,
    input wire i_id_below_ref,
    input wire i_ov_weak,
    input wire i_ov_strong,
    input wire i_below_hys,
    input wire i_above_uvlo,
    input wire [`ADC_W-1:0] i_adc_code,
    input wire i_adc_done,
    input wire i_int_read,
    input wire i_int_mask,
    // Outputs watched
    input wire o_adc_start,
    input wire o_imp_measure,
    input wire [`ADC_W-1:0] o_acc_type_ff,
    input wire o_standby,
    input wire o_vbus_switch_on,
    input wire o_overvoltage_flag_ff,
    input wire o_overvoltage_cleared_flag_ff,
    input wire o_interrupt_out_n_ff
);
    // Cycles of overvoltage seen while the supply switch is still on
    reg [6:0] ov_run_ff;
    always @(posedge i_sys_clk)
        ov_run_ff <= (i_srst || !o_vbus_switch_on || !(i_ov_weak || i_ov_strong)) ?
            7'h0 : ov_run_ff + 7'h1;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    sequence s_insert;
        o_standby && (i_vbus_high || i_id_below_ref);
    endsequence
    sequence s_settled;
        $past(i_below_hys) && $past(i_above_uvlo);
    endsequence
    a_reset_defaults: assert property (disable iff (1'b0) i_srst |=> o_standby &&
        o_acc_type_ff == 5'h1f && o_interrupt_out_n_ff && o_vbus_switch_on)
        else $error("reset defaults wrong");
    a_insert_measure: assert property (s_insert |=> o_adc_start && !o_standby)
        else $error("insertion not measured");
    a_imp_when_vbus: assert property (o_imp_measure |-> o_adc_start && i_vbus_high)
        else $error("impedance measure out of place");
    a_type_stored: assert property (o_adc_start && i_adc_done |=>
        o_acc_type_ff == $past(i_adc_code)) else $error("type not stored");
    a_trip_bound: assert property (ov_run_ff <= 7'h34)
        else $error("overvoltage trip too slow");
    a_trip_flag: assert property ($fell(o_vbus_switch_on) |-> ##[0:2] o_overvoltage_flag_ff)
        else $error("overvoltage flag missing");
    a_recover_cause: assert property ($rose(o_vbus_switch_on) |-> s_settled)
        else $error("switch back on without recovery");
    a_cleared_flag: assert property ($rose(o_vbus_switch_on) |->
        ##[0:2] o_overvoltage_cleared_flag_ff) else $error("cleared flag missing");
    a_int_low: assert property (o_overvoltage_flag_ff && !i_int_mask && !i_int_read |=>
        !o_interrupt_out_n_ff) else $error("interrupt not driven");
    // A trip or clear landing in the read cycle wins over the read
    a_read_clears: assert property (i_int_read && !$changed(o_vbus_switch_on) |=>
        !o_overvoltage_flag_ff && !o_overvoltage_cleared_flag_ff) else $error("flags kept");
endmodule // accessory_detect_switch_ctrl_monitor

// ==== sim/accessory_detect_switch_ctrl_test.sv ====
// Directed tests for the accessory detect and switch control block
`timescale 1ns/1ps
`include "acc_ctrl_defs.vh"
module accessory_detect_switch_ctrl_test;
    reg clk = 0, srst = 1, vb = 0, idl = 0, ovw = 0, ovs = 0, hys = 0, uv = 1;
    reg sp = 0, mm = 0, rd = 0, mk = 0, scl = 0, sda = 0;
    reg [7:0] msw = 8'h00;
    reg [4:0] sel = 5'h00;
    reg [3:0] lat = 4'h2;
    wire done, st, imp, att, von, ovf, ovc, intn, stby, af, df;
    wire [4:0] code, typ;
    wire [7:0] sw;
    integer n_errors = 0, comparisons = 0, i, k;
    always #10 clk = ~clk;
    accessory_detect_switch_ctrl #(.SWRST_CYC(50), .RECOV_CYC(8), .AV_HOLD_CYC(16)) dut (
        .i_sys_clk(clk), .i_srst(srst), .i_vbus_high(vb), .i_id_below_ref(idl),
        .i_ov_weak(ovw), .i_ov_strong(ovs), .i_below_hys(hys), .i_above_uvlo(uv),
        .i_sync_pulse(sp), .i_adc_code(code), .i_adc_done(done), .o_adc_start(st),
        .o_imp_measure(imp), .i_manual_mode(mm), .i_manual_sw(msw), .i_int_read(rd),
        .i_int_mask(mk), .i_scl_low(scl), .i_sda_low(sda), .o_acc_type_ff(typ),
        .o_attached_ff(att), .o_switch_ff(sw), .o_vbus_switch_on(von),
        .o_overvoltage_flag_ff(ovf), .o_overvoltage_cleared_flag_ff(ovc),
        .o_attach_flag_ff(af), .o_detach_flag_ff(df), .o_interrupt_out_n_ff(intn),
        .o_standby(stby));
    acc_adc_model adc (.i_sys_clk(clk), .i_start(st), .i_lat(lat), .i_code(sel),
        .o_done(done), .o_code(code));
    // Inputs move 1 ns after the edge so sampling never races
    task wt(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input [7:0] g, input [7:0] e);
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task attach;
        for (i = 0; i < 30 && att !== 1'b1; i = i + 1)
            wt(1);
    endtask
    task conclude;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_errors = n_errors + 1;
        conclude;
    end
    initial
    begin
        wt(3);
        srst = 0;
        chk(stby, 1);
        chk(typ, `ADC_NONE);
        chk(sw, `SW_OPEN);
        $display("reset test done");
        sel = `ADC_UART;
        vb = 1;
        wt(1);
        chk(imp, 1);
        attach;
        chk(typ, `ADC_UART);
        chk(af, 1);
        wt(1);
        chk(sw, `SW_UART);
        chk(intn, 0);
        rd = 1;
        wt(1);
        rd = 0;
        wt(1);
        chk(intn, 1);
        chk(af, 0);
        mm = 1;
        msw = 8'h05;
        wt(2);
        chk(sw, 8'h05);
        mm = 0;
        wt(2);
        chk(sw, `SW_UART);
        $display("attach and switch test done");
        vb = 0;
        mk = 1;
        scl = 1;
        sda = 1;
        wt(60);
        chk(typ, `ADC_NONE);
        // While the lines are held the logic sits in reset, interrupt released
        chk(intn, 1);
        scl = 0;
        sda = 0;
        wt(5);
        chk(intn, 0);
        mk = 0;
        wt(3);
        chk(intn, 1);
        $display("soft reset test done");
        sel = `ADC_AV;
        lat = 4'h6;
        idl = 1;
        attach;
        chk(typ, `ADC_AV);
        idl = 0;
        for (k = 0; k < 20; k = k + 1)
        begin
            sp = ~sp;
            wt(2);
        end
        chk(att, 1);
        chk(sw, `SW_VIDEO | `SW_AUDIO);
        // Without sync pulses the hold window must run out
        wt(20);
        chk(att, 0);
        chk(df, 1);
        $display("video cable test done");
        // Strong excursion must trip well before a weak one of the same length
        for (k = 0; k < 2; k = k + 1)
        begin
            ovs = (k == 0);
            ovw = (k == 1);
            wt(k ? 45 : 10);
            chk(von, 1);
            wt(k ? 8 : 17);
            chk(von, 0);
            wt(1);
            chk(ovf, 1);
            ovs = 0;
            ovw = 0;
            hys = 1;
            wt(4);
            chk(von, 0);
            wt(8);
            chk(von, 1);
            wt(1);
            chk(ovc, 1);
            hys = 0;
            rd = 1;
            wt(1);
            rd = 0;
            wt(1);
            chk(ovf, 0);
            chk(intn, 1);
        end
        $display("overvoltage test done");
        conclude;
    end
endmodule // accessory_detect_switch_ctrl_test
bind accessory_detect_switch_ctrl accessory_detect_switch_ctrl_monitor mon (.i_sys_clk,
    .i_srst, .i_vbus_high, .i_id_below_ref, .i_ov_weak, .i_ov_strong, .i_below_hys,
    .i_above_uvlo, .i_adc_code, .i_adc_done, .i_int_read, .i_int_mask, .o_adc_start,
    .o_imp_measure, .o_acc_type_ff, .o_standby, .o_vbus_switch_on, .o_overvoltage_flag_ff,
    .o_overvoltage_cleared_flag_ff, .o_interrupt_out_n_ff);
